// ==== inc/bfs_pkg.sv ====
// Package with constants, timing figures and state codes of the ballast fault supervisor.
package bfs_pkg;
  // ****************************************************************
  // Clock rate and timing figures
  // ****************************************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned T_INV_OC_NS   = 400;
  localparam int unsigned T_PFC_OC_NS   = 260;
  localparam int unsigned T_ILIM_NS     = 250;
  localparam int unsigned T_OPEN_NS     = 1_000;
  localparam int unsigned T_PFC_OV_NS   = 5_000;
  localparam int unsigned T_UV_NS       = 80_000;
  localparam int unsigned T_STARTOV_NS  = 10_000;
  localparam int unsigned T_SEVERE_NS   = 40_000;
  localparam int unsigned T_SEVERE_LIM_NS = 605_000;
  localparam int unsigned T_PREPOWER_US = 1_000;
  localparam int unsigned T_EOL_TICK_US = 4_000;
  localparam int unsigned T_EOL_LIM_MS  = 500;
  localparam int unsigned T_IGN_LIM_MS  = 235;
  localparam int unsigned T_PRERUN_MS   = 250;
  localparam int unsigned T_SOFT_MS     = 10;
  localparam int unsigned BLANK_CYCLES  = 32;

  // Least times round up to whole clock cycles, never below one.
  function automatic int unsigned ns_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned CYC_INV_OC  = ns_up(T_INV_OC_NS);
  localparam int unsigned CYC_PFC_OC  = ns_up(T_PFC_OC_NS);
  localparam int unsigned CYC_ILIM    = ns_up(T_ILIM_NS);
  localparam int unsigned CYC_OPEN    = ns_up(T_OPEN_NS);
  localparam int unsigned CYC_PFC_OV  = ns_up(T_PFC_OV_NS);
  localparam int unsigned CYC_UV      = ns_up(T_UV_NS);
  localparam int unsigned CYC_STARTOV = ns_up(T_STARTOV_NS);
  localparam int unsigned CYC_SEVERE_TICK = ns_up(T_SEVERE_NS);
  localparam int unsigned SEVERE_LIM  = (T_SEVERE_LIM_NS + T_SEVERE_NS - 1) / T_SEVERE_NS;
  localparam int unsigned CYC_PREPOWER = T_PREPOWER_US * (1_000 / CLK_NS);
  localparam int unsigned CYC_EOL_TICK = T_EOL_TICK_US * (1_000 / CLK_NS);
  localparam int unsigned EOL_LIM     = (T_EOL_LIM_MS * 1_000 + T_EOL_TICK_US - 1) / T_EOL_TICK_US;
  localparam int unsigned CYC_IGN     = T_IGN_LIM_MS * 1_000 * (1_000 / CLK_NS);
  localparam int unsigned CYC_PRERUN  = T_PRERUN_MS * 1_000 * (1_000 / CLK_NS);
  localparam int unsigned CYC_SOFT    = T_SOFT_MS * 1_000 * (1_000 / CLK_NS);

  localparam int unsigned FW = 16;   // short filter counter width
  localparam int unsigned LW = 24;   // long timer width
  localparam int unsigned KW = 8;    // integration counter width

  // ****************************************************************
  // Operating phases, one-hot
  // ****************************************************************
  typedef enum logic [7:0] {
    BFS_OFF     = 8'b0000_0001,
    BFS_CHECK   = 8'b0000_0010,
    BFS_SOFT    = 8'b0000_0100,
    BFS_PREHEAT = 8'b0000_1000,
    BFS_IGNITE  = 8'b0001_0000,
    BFS_PRERUN  = 8'b0010_0000,
    BFS_RUN     = 8'b0100_0000,
    BFS_FAULT   = 8'b1000_0000
  } bfs_phase_t;

  // Per-phase enable mask bits: soft, preheat, ignite, prerun, run.
  typedef logic [4:0] bfs_mask_t;
  localparam bfs_mask_t MASK_ALL    = 5'b1_1111;
  localparam bfs_mask_t MASK_RUN    = 5'b1_0000;
  localparam bfs_mask_t MASK_SEVERE = 5'b1_0010;
  localparam bfs_mask_t MASK_IGNITE = 5'b0_0100;
endpackage

// ==== design/bfs_supervisor.sv ====
// Fault supervision and restart sequencing for a lamp ballast controller.
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) Inverter overcurrent past filter: latch fault
// (R2) Mild capacitive persisting in run: latch fault
// (R3) Severe capacitive in preheat/run: latch fault
// (R4) Severe integrator samples every fixed period
// (R5) Low-side turn-on sample flags mild condition
// (R6) High-side turn-on sample flags severe condition
// (R7) Floating reference refreshed each low-side on-time
// (R8) Fault latch disables all drives immediately
// (R9) Blanking of 32 cycles before removal detection
// (R10) Latch clears after removal then reinsertion
// (R11) Undervoltage lockout resets latches, blocks start
// (R12) Bus undervoltage in run: drives off, unlatched
// (R13) Open filament in run: latch fault
// (R14) Lamp ratio or peak fault: latch fault
// (R15) Bus overvoltage in run: latch fault
// (R16) Overvoltage after power-up: drives off, unlatched
// (R17) Bus overvoltage holds PFC off until recovery
// (R18) Open loop bus: power down, unlatched
// (R19) No run frequency within ignition limit: latch
// (R20) Open filament before power-up blocks start
// (R21) PFC overcurrent turns PFC switch off
// (R22) Ignition current limit raises frequency
// (R23) End-of-life integration on fixed tick
// (R24) Pre-run period disables EOL and mild checks
// (R25) Track phase, gate detectors by mask
module bfs_supervisor
  import bfs_pkg::*;
(
  // Clock and reset; reset stands for the undervoltage lockout.
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Supply comparators.
  input  wire logic vcc_above_start,
  input  wire logic vcc_above_uvlo,
  // Inverter and PFC comparators.
  input  wire logic lowside_current_sense,
  input  wire logic lowside_current_low,
  input  wire logic pfc_current_sense,
  input  wire logic bus_over,
  input  wire logic bus_recovered,
  input  wire logic bus_under,
  input  wire logic bus_open_loop,
  // Lamp and filament comparators.
  input  wire logic lamp_sense_input_one,
  input  wire logic lamp_sense_input_two,
  input  wire logic lamp_peak_fault,
  input  wire logic lamp_rectification_fault,
  input  wire logic filament_sense_pin,
  input  wire logic fil_open_level,
  input  wire logic fil_removal,
  input  wire logic fil_reinsert,
  input  wire logic fil_above_cap_offset,
  input  wire logic fil_below_cap_offset,
  // Gate drive timing and phase progress from the frequency generator.
  input  wire logic lowside_gate_on,
  input  wire logic highside_gate_on,
  input  wire logic preheat_done,
  input  wire logic run_freq_reached,
  input  wire logic blank_cycle_done,
  // Outputs.
  output var  logic gate_enable,
  output var  logic pfc_enable,
  output var  logic freq_raise,
  output var  logic fault_latched,
  output var  logic ref_refresh,
  output var  logic fil_cap_cycle,
  output var  logic mild_capacitive_condition,
  output var  logic severe_capacitive_condition,
  output var  logic [7:0] phase_out
);
  import bfs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bfs_phase_t      phase;
    logic [LW-1:0]   tmr;
    logic [FW-1:0]   f_invoc;
    logic [FW-1:0]   f_pfcoc;
    logic [FW-1:0]   f_ilim;
    logic [FW-1:0]   f_open;
    logic [FW-1:0]   f_pfcov;
    logic [FW-1:0]   f_uv;
    logic [FW-1:0]   f_pre;
    logic [FW-1:0]   sev_tick;
    logic [KW-1:0]   sev_cnt;
    logic [LW-1:0]   eol_tick;
    logic [KW-1:0]   eol_cnt;
    logic [5:0]      blank;
    logic            removed;
    logic            pfc_hold;
    logic            lsg_q;
    logic            hsg_q;
    logic            gate_en;
    logic            pfc_en;
    logic            raise;
    logic            latch;
    logic            mild;
    logic            severe;
    logic            refr;
    logic            capcyc;
    logic            need_cycle;
  } bfs_state_t;

  bfs_state_t s_q;
  bfs_state_t s_d;

  // Counts a filter up while the condition holds, clears it otherwise.
  function automatic logic [FW-1:0] filt(input logic c, input logic [FW-1:0] f,
                                         input int unsigned lim);
    if (!c) return '0;
    if (f >= FW'(lim)) return f;
    return f + FW'(1);
  endfunction

  function automatic logic [KW-1:0] updn(input logic c, input logic [KW-1:0] k);
    if (c) return (k == '1) ? k : k + KW'(1);
    return (k == '0) ? k : k - KW'(1);
  endfunction

  bfs_mask_t cur;
  always_comb begin
    unique case (s_q.phase)
      BFS_SOFT:    cur = 5'b0_0001;
      BFS_PREHEAT: cur = 5'b0_0010;
      BFS_IGNITE:  cur = 5'b0_0100;
      BFS_PRERUN:  cur = 5'b0_1000;
      BFS_RUN:     cur = 5'b1_0000;
      default:     cur = '0;
    endcase
  end

  logic active;
  logic lsg_rise;
  logic hsg_rise;
  logic run_on;
  logic eol_any;
  assign active   = |cur;
  assign lsg_rise = lowside_gate_on & ~s_q.lsg_q;
  assign hsg_rise = highside_gate_on & ~s_q.hsg_q;
  assign run_on   = |(cur & MASK_RUN);                                      // see (R25)
  assign eol_any  = s_q.mild | fil_open_level | lamp_peak_fault
                  | lamp_rectification_fault | bus_over;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic go_latch;
    logic go_off;
    go_latch = 1'b0;
    go_off   = 1'b0;
    s_d      = s_q;
    s_d.lsg_q = lowside_gate_on;
    s_d.hsg_q = highside_gate_on;
    s_d.tmr   = s_q.tmr + LW'(1);

    s_d.f_invoc = filt(lowside_current_sense & active, s_q.f_invoc, CYC_INV_OC);
    s_d.f_pfcoc = filt(pfc_current_sense, s_q.f_pfcoc, CYC_PFC_OC);
    s_d.f_ilim  = filt(lowside_current_low & |(cur & MASK_IGNITE), s_q.f_ilim, CYC_ILIM);
    s_d.f_open  = filt(bus_open_loop & active, s_q.f_open, CYC_OPEN);
    s_d.f_pfcov = filt(bus_over & active, s_q.f_pfcov, CYC_PFC_OV);
    s_d.f_uv    = filt(bus_under & run_on, s_q.f_uv, CYC_UV);

    // Capacitive sampling at the gate turn-on edges.
    s_d.refr = lowside_gate_on & active;                                   // see (R7)
    if (lsg_rise && active) begin
      s_d.mild = fil_above_cap_offset;                                     // see (R5)
    end
    if (hsg_rise && active) begin
      s_d.severe = fil_below_cap_offset;                                   // see (R6)
    end

    // Severe integrator, only where the mask allows it.
    if (|(cur & MASK_SEVERE)) begin
      if (s_q.sev_tick >= FW'(CYC_SEVERE_TICK - 1)) begin
        s_d.sev_tick = '0;
        s_d.sev_cnt  = updn(s_q.severe, s_q.sev_cnt);                       // see (R4)
      end else begin
        s_d.sev_tick = s_q.sev_tick + FW'(1);
      end
    end else begin
      s_d.sev_tick = '0;
      s_d.sev_cnt  = '0;
    end

    // Shared end-of-life integrator, run phase only.
    if (run_on) begin
      if (s_q.eol_tick >= LW'(CYC_EOL_TICK - 1)) begin
        s_d.eol_tick = '0;
        s_d.eol_cnt  = updn(eol_any, s_q.eol_cnt);                         // see (R23)
      end else begin
        s_d.eol_tick = s_q.eol_tick + LW'(1);
      end
    end else begin
      s_d.eol_tick = '0;                                                   // see (R24)
      s_d.eol_cnt  = '0;
    end

    // PFC overvoltage hold with hysteresis.
    if (s_q.f_pfcov >= FW'(CYC_PFC_OV)) begin
      s_d.pfc_hold = 1'b1;                                                 // see (R17)
    end else if (bus_recovered) begin
      s_d.pfc_hold = 1'b0;
    end

    if (s_q.f_invoc >= FW'(CYC_INV_OC)) go_latch = 1'b1;                    // see (R1)
    if (s_q.eol_cnt >= KW'(EOL_LIM)) go_latch = 1'b1;              // see (R2) (R13) (R14) (R15)
    if (s_q.sev_cnt >= KW'(SEVERE_LIM)) go_latch = 1'b1;                    // see (R3)
    if (s_q.phase == BFS_IGNITE && s_q.tmr >= LW'(CYC_IGN)) go_latch = 1'b1; // see (R19)
    if (s_q.f_uv >= FW'(CYC_UV)) go_off = 1'b1;                             // see (R12)
    if (s_q.f_open >= FW'(CYC_OPEN)) go_off = 1'b1;                         // see (R18)
    if (!vcc_above_uvlo) go_off = 1'b1;                                     // see (R11)

    unique case (s_q.phase)
      BFS_OFF: begin
        s_d.tmr = '0;
        s_d.latch = 1'b0;                                                  // see (R11)
        s_d.f_pre = '0;
        // An unlatched stop may only restart once the supply has dipped below lockout.
        if (vcc_above_uvlo && !s_q.need_cycle) s_d.phase = BFS_CHECK;   // see (R12)
      end
      BFS_CHECK: begin
        s_d.f_pre = filt(fil_open_level | ~lamp_sense_input_one | ~lamp_sense_input_two,
                         s_q.f_pre, CYC_PREPOWER);
        // The check runs a full filter time first, so an open filament can mature
        // before the bridge starts; the timer then holds instead of wrapping.
        if (s_q.tmr >= LW'(CYC_PREPOWER)) s_d.tmr = s_q.tmr;
        if (!vcc_above_uvlo) begin
          s_d.phase = BFS_OFF;
        end else if (vcc_above_start && s_q.tmr >= LW'(CYC_PREPOWER)
                     && s_q.f_pre < FW'(CYC_PREPOWER) && !bus_open_loop) begin  // see (R20)
          s_d.phase = BFS_SOFT;
          s_d.tmr   = '0;
        end
      end
      BFS_SOFT: begin
        if (s_q.tmr >= LW'(CYC_SOFT)) begin
          s_d.phase = BFS_PREHEAT;
          s_d.tmr = '0;
        end
      end
      BFS_PREHEAT: begin
        if (preheat_done) begin
          s_d.phase = BFS_IGNITE;
          s_d.tmr = '0;
        end
      end
      BFS_IGNITE: begin
        if (run_freq_reached) begin
          s_d.phase = BFS_PRERUN;
          s_d.tmr = '0;
        end
      end
      BFS_PRERUN: begin
        if (s_q.tmr >= LW'(CYC_PRERUN)) begin
          s_d.phase = BFS_RUN;                                             // see (R24)
          s_d.tmr = '0;
        end
      end
      BFS_RUN: begin
        s_d.tmr = '0;
      end
      BFS_FAULT: begin
        s_d.tmr = '0;
        if (s_q.blank < 6'(BLANK_CYCLES)) begin
          s_d.capcyc = 1'b1;                                               // see (R9)
          if (blank_cycle_done) s_d.blank = s_q.blank + 6'(1);
        end else begin
          s_d.capcyc = 1'b0;
          if (fil_removal) s_d.removed = 1'b1;
          if (s_q.removed && fil_reinsert) begin
            s_d.latch = 1'b0;                                              // see (R10)
            s_d.phase = BFS_CHECK;
          end
        end
      end
      default: s_d.phase = BFS_OFF;
    endcase

    // Startup overvoltage: no gate drive, wait for the supply to cycle.
    if (s_q.phase == BFS_SOFT && s_q.tmr == LW'(CYC_STARTOV) && bus_over) begin
      go_off = 1'b1;                                                       // see (R16)
    end

    if (go_latch && active) begin
      s_d.phase   = BFS_FAULT;
      s_d.latch   = 1'b1;
      s_d.blank   = '0;
      s_d.removed = 1'b0;
      s_d.capcyc  = 1'b1;
    end else if (go_off && s_q.phase != BFS_FAULT) begin
      // Unlatched stop: the restart needs a full supply hysteresis cycle.
      s_d.phase      = BFS_OFF;
      s_d.need_cycle = 1'b1;                                               // see (R12)
    end
    if (!vcc_above_uvlo) begin
      s_d.phase      = BFS_OFF;
      s_d.latch      = 1'b0;
      s_d.need_cycle = 1'b0;                                               // see (R11)
    end

    // Drives follow the next phase, so any shutdown acts in one edge.
    s_d.gate_en = s_d.phase inside {BFS_SOFT, BFS_PREHEAT, BFS_IGNITE, BFS_PRERUN, BFS_RUN};
    s_d.pfc_en  = s_d.gate_en & ~s_d.pfc_hold                                // see (R8)
                & ~(pfc_current_sense && s_d.f_pfcoc >= FW'(CYC_PFC_OC));    // see (R21)
    s_d.raise   = s_d.f_ilim >= FW'(CYC_ILIM);                             // see (R22)
    if (!s_d.gate_en) begin
      s_d.mild   = 1'b0;
      s_d.severe = 1'b0;
      s_d.refr   = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '{phase: BFS_OFF, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs straight from flip-flops
  // ****************************************************************
  always_comb begin
    gate_enable                 = s_q.gate_en;
    pfc_enable                  = s_q.pfc_en;
    freq_raise                  = s_q.raise;
    fault_latched               = s_q.latch;
    ref_refresh                 = s_q.refr;
    fil_cap_cycle               = s_q.capcyc;
    mild_capacitive_condition   = s_q.mild;
    severe_capacitive_condition = s_q.severe;
    phase_out                   = s_q.phase;
  end
endmodule
`default_nettype wire

// ==== dv/bfs_comparator_model.sv ====
// Behavioural model of the gate timing and filament capacitor comparators.
`timescale 1ns/1ps
`default_nettype none
module bfs_comparator_model (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Supervisor outputs that pace the model.
  input  wire logic gate_enable,
  input  wire logic fil_cap_cycle,
  // Gate timing and blanking progress.
  output var  logic lowside_gate_on,
  output var  logic highside_gate_on,
  output var  logic blank_cycle_done
);
  logic [3:0] gate_cnt_q;
  logic [2:0] blank_cnt_q;

  // The bridge stops with the drives, so no gate edge appears after a shutdown.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !gate_enable) begin
      gate_cnt_q <= 4'h0;
    end else begin
      gate_cnt_q <= gate_cnt_q + 4'h1;
    end
    if (sys_rst || !fil_cap_cycle) begin
      blank_cnt_q <= 3'h0;
    end else begin
      blank_cnt_q <= blank_cnt_q + 3'h1;
    end
  end

  // Two dead cycles separate the two gates to keep the half bridge shoot-through free.
  assign lowside_gate_on  = gate_enable && (gate_cnt_q inside {[4'h1:4'h6]});
  assign highside_gate_on = gate_enable && (gate_cnt_q inside {[4'h9:4'hE]});
  // One discharge and recharge of the capacitor every eight clocks.
  assign blank_cycle_done = fil_cap_cycle && (blank_cnt_q == 3'h7);
endmodule
`default_nettype wire

// ==== dv/bfs_supervisor_checker.sv ====
// Concurrent checks on the ports of the ballast fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module bfs_supervisor_checker (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Watched inputs.
  input  wire logic       lowside_current_sense,
  input  wire logic       pfc_current_sense,
  input  wire logic       lowside_gate_on,
  input  wire logic       fil_reinsert,
  input  wire logic       vcc_above_uvlo,
  // Watched outputs.
  input  wire logic       gate_enable,
  input  wire logic       pfc_enable,
  input  wire logic       freq_raise,
  input  wire logic       fault_latched,
  input  wire logic       ref_refresh,
  input  wire logic       fil_cap_cycle,
  input  wire logic [7:0] phase_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic active;
  assign active = phase_out inside {8'h04, 8'h08, 8'h10, 8'h20, 8'h40};

  sequence s_inv_oc;
    (lowside_current_sense && active) [*5];
  endsequence
  sequence s_pfc_oc;
    pfc_current_sense [*4];
  endsequence
  sequence s_shutdown;
    fault_latched && !gate_enable && !pfc_enable && phase_out == 8'h80;
  endsequence

  a_inv_oc_latch: assert property (s_inv_oc |-> ##[1:3] s_shutdown)
    else $error("inverter overcurrent did not latch a fault");
  a_pfc_oc_off: assert property (s_pfc_oc |-> ##[0:2] !pfc_enable)
    else $error("pfc switch stayed on during overcurrent");
  a_fault_drives_off: assert property (fault_latched |-> s_shutdown)
    else $error("drives active while fault latched");
  a_blank_on_fault: assert property ($rose(fault_latched) |-> fil_cap_cycle)
    else $error("blanking did not start with the fault");
  a_freq_raise_ign: assert property (
    freq_raise |-> (phase_out == 8'h10 || $past(phase_out) == 8'h10))
    else $error("frequency raised outside ignition");
  a_ref_refresh_ls: assert property (ref_refresh |-> $past(lowside_gate_on))
    else $error("reference refreshed without low side on time");
  a_latch_clear_cause: assert property ($fell(fault_latched) |->
    ($past(fil_reinsert) || !$past(vcc_above_uvlo) || !$past(vcc_above_uvlo, 2)))
    else $error("fault latch cleared without reinsertion or lockout");
  a_idle_drives_off: assert property (phase_out == 8'h01 |-> !gate_enable && !pfc_enable)
    else $error("drives active while powered down");
endmodule

bind bfs_supervisor bfs_supervisor_checker u_chk (
  .clk_sys, .sys_rst, .lowside_current_sense, .pfc_current_sense, .lowside_gate_on,
  .fil_reinsert, .vcc_above_uvlo, .gate_enable, .pfc_enable, .freq_raise,
  .fault_latched, .ref_refresh, .fil_cap_cycle, .phase_out
);
`default_nettype wire

// ==== dv/tb_bfs_supervisor.sv ====
// Self-checking testbench of the ballast fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_bfs_supervisor;
  localparam int TIMEOUT_CYCLES = 90_000;
  logic       clk_sys, sys_rst, vcc_above_start, vcc_above_uvlo;
  logic       lowside_current_sense, lowside_current_low, pfc_current_sense;
  logic       bus_over, bus_recovered, bus_under, bus_open_loop;
  logic       lamp_sense_input_one, lamp_sense_input_two, lamp_peak_fault;
  logic       lamp_rectification_fault, filament_sense_pin, fil_open_level;
  logic       fil_removal, fil_reinsert, fil_above_cap_offset, fil_below_cap_offset;
  logic       lowside_gate_on, highside_gate_on, preheat_done, run_freq_reached;
  logic       blank_cycle_done, gate_enable, pfc_enable, freq_raise, fault_latched;
  logic       ref_refresh, fil_cap_cycle, mild_capacitive_condition;
  logic       severe_capacitive_condition;
  logic [7:0] phase_out;
  int         miscompares, checks, cycles;

  bfs_supervisor u_dut (
    .clk_sys, .sys_rst, .vcc_above_start, .vcc_above_uvlo, .lowside_current_sense,
    .lowside_current_low, .pfc_current_sense, .bus_over, .bus_recovered, .bus_under,
    .bus_open_loop, .lamp_sense_input_one, .lamp_sense_input_two, .lamp_peak_fault,
    .lamp_rectification_fault, .filament_sense_pin, .fil_open_level, .fil_removal,
    .fil_reinsert, .fil_above_cap_offset, .fil_below_cap_offset, .lowside_gate_on,
    .highside_gate_on, .preheat_done, .run_freq_reached, .blank_cycle_done,
    .gate_enable, .pfc_enable, .freq_raise, .fault_latched, .ref_refresh,
    .fil_cap_cycle, .mild_capacitive_condition, .severe_capacitive_condition, .phase_out
  );
  bfs_comparator_model u_far (
    .clk_sys, .sys_rst, .gate_enable, .fil_cap_cycle, .lowside_gate_on,
    .highside_gate_on, .blank_cycle_done
  );

  always #50 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    checks++;
    if (act !== exp) begin
      miscompares++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wait_phase(input logic [7:0] ph, input int lim);
    int n;
    n = 0;
    while (phase_out !== ph && n < lim) begin
      tick(1);
      #1;
      n++;
    end
    chk(ph, phase_out);
  endtask

  task automatic t_startup;
    logic seen;
    seen = 1'b0;
    tick(11_000);
    #1;
    chk(8'h00, {7'h00, phase_out == 8'h04});
    tick(1);
    lamp_sense_input_two <= 1'b1;
    wait_phase(8'h04, 20_000);
    chk(8'h03, {6'h00, gate_enable, pfc_enable});
    repeat (32) begin
      tick(1);
      #1;
      seen = seen | ref_refresh;
    end
    chk(8'h01, {7'h00, seen});
  endtask

  task automatic t_pfc_oc;
    tick(1);
    pfc_current_sense <= 1'b1;
    tick(2);
    pfc_current_sense <= 1'b0;
    tick(3);
    #1;
    chk(8'h01, {7'h00, pfc_enable});
    tick(1);
    pfc_current_sense <= 1'b1;
    tick(5);
    #1;
    chk(8'h00, {7'h00, pfc_enable});
    tick(1);
    pfc_current_sense <= 1'b0;
  endtask

  task automatic t_capacitive;
    tick(1);
    fil_above_cap_offset <= 1'b1;
    fil_below_cap_offset <= 1'b1;
    lowside_current_low  <= 1'b1;
    tick(20);
    #1;
    chk(8'h03, {5'h00, freq_raise, mild_capacitive_condition,
                severe_capacitive_condition});
    tick(1);
    fil_above_cap_offset <= 1'b0;
    fil_below_cap_offset <= 1'b0;
    lowside_current_low  <= 1'b0;
    tick(20);
    #1;
    chk(8'h00, {5'h00, freq_raise, mild_capacitive_condition,
                severe_capacitive_condition});
  endtask

  task automatic t_inv_oc;
    tick(1);
    lowside_current_sense <= 1'b1;
    tick(3);
    lowside_current_sense <= 1'b0;
    tick(3);
    #1;
    chk(8'h00, {7'h00, fault_latched});
    tick(1);
    lowside_current_sense <= 1'b1;
    tick(7);
    #1;
    chk(8'h80, phase_out);
    chk(8'h09, {4'h0, fault_latched, gate_enable, pfc_enable, fil_cap_cycle});
    tick(1);
    lowside_current_sense <= 1'b0;
  endtask

  // Removal seen inside the blanking time must not clear the latch.
  task automatic t_removal;
    int n;
    n = 0;
    tick(20);
    fil_removal <= 1'b1;
    fil_reinsert <= 1'b0;
    tick(20);
    fil_removal <= 1'b0;
    fil_reinsert <= 1'b1;
    while (fil_cap_cycle === 1'b1 && n < 2_000) begin
      tick(1);
      #1;
      n++;
    end
    chk(8'h01, {7'h00, fault_latched});
    chk(8'h01, {7'h00, n >= 200 && n < 2_000});
    tick(1);
    fil_removal <= 1'b1;
    fil_reinsert <= 1'b0;
    tick(20);
    fil_removal <= 1'b0;
    fil_reinsert <= 1'b1;
    tick(10);
    #1;
    chk(8'h00, {7'h00, fault_latched});
  endtask

  task automatic t_uvlo;
    wait_phase(8'h04, 20_000);
    t_inv_oc();
    tick(1);
    vcc_above_uvlo <= 1'b0;
    vcc_above_start <= 1'b0;
    tick(4);
    #1;
    chk(8'h01, phase_out);
    chk(8'h00, {7'h00, fault_latched});
    tick(1);
    vcc_above_uvlo <= 1'b1;
    tick(11_000);
    #1;
    chk(8'h00, {7'h00, phase_out == 8'h04});
    tick(1);
    vcc_above_start <= 1'b1;
    wait_phase(8'h04, 20_000);
  endtask

  task automatic t_open_loop;
    tick(1);
    bus_open_loop <= 1'b1;
    tick(5);
    bus_open_loop <= 1'b0;
    tick(4);
    #1;
    chk(8'h04, phase_out);
    tick(1);
    bus_open_loop <= 1'b1;
    tick(16);
    #1;
    chk(8'h01, phase_out);
    chk(8'h00, {7'h00, fault_latched});
  endtask

  initial begin
    {sys_rst, vcc_above_start, vcc_above_uvlo} = 3'h7;
    {clk_sys, lowside_current_sense, lowside_current_low, pfc_current_sense} = 4'h0;
    {bus_over, bus_recovered, bus_under, bus_open_loop} = 4'h4;
    {lamp_sense_input_one, lamp_sense_input_two, lamp_peak_fault} = 3'h4;
    {lamp_rectification_fault, filament_sense_pin, fil_open_level, fil_removal} = 4'h0;
    {fil_reinsert, fil_above_cap_offset, fil_below_cap_offset} = 3'h4;
    {preheat_done, run_freq_reached} = 2'h0;
    {miscompares, checks, cycles} = '0;
    tick(12);
    #1;
    chk(8'h01, phase_out);
    chk(8'h00, {gate_enable, pfc_enable, freq_raise, fault_latched, ref_refresh,
                fil_cap_cycle, mild_capacitive_condition, severe_capacitive_condition});
    tick(1);
    sys_rst <= 1'b0;
    t_startup();
    t_pfc_oc();
    t_capacitive();
    t_inv_oc();
    t_removal();
    t_uvlo();
    t_open_loop();
    stop_test();
  end
endmodule
`default_nettype wire
